// >>> logic/fault_latch_flags.sv
`timescale 1ns/10ps
module fault_latch_flags (
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       srst,
   // Register port
   input  wire logic       reg_wr,
   input  wire logic       reg_rd,
   input  wire logic [7:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   output logic      [7:0] reg_rdata,
   // Fault events, asynchronous to clk
   input  wire logic       logic_selftest_fail,
   input  wire logic       analog_selftest_fail,
   input  wire logic       temp_orderly_over,
   input  wire logic       temp_immediate_over,
   input  wire logic       input_supply_overvoltage,
   input  wire logic       power_sequencer_error,
   input  wire logic       regulators_off,
   // Regulator control
   input  wire logic       regulator_enable_req,
   output logic            regulator_enable_ok
);
   localparam int N = fault_flag_pkg::NUM_FLAGS;

   // Bit map below wires exactly five flags
   if (N != 5) begin : g_bad_flag_count
      $error("fault_latch_flags expects five flags");
   end

   // ---------------------------------------------
   // Input synchronisers
   // ---------------------------------------------
   logic [6:0] sync1_r;
   logic [6:0] sync2_r;
   logic [6:0] sync1_nxt;
   logic [6:0] sync2_nxt;
   logic       ev_bist;
   logic       ev_tord;
   logic       ev_timm;
   logic       ev_ovp;
   logic       ev_seq;
   logic       regs_off;
   logic       live_tord;
   logic       live_timm;

   always_comb begin
      sync1_nxt = {regulators_off, power_sequencer_error, input_supply_overvoltage,
                   temp_immediate_over, temp_orderly_over, analog_selftest_fail, logic_selftest_fail};
      sync2_nxt = sync1_r;
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         sync1_r <= 7'h00;
         sync2_r <= 7'h00;
      end else begin
         sync1_r <= sync1_nxt;
         sync2_r <= sync2_nxt;
      end
   end

   // Shutdown flags latch only once the regulators are already off
   assign regs_off  = sync2_r[6];
   assign live_tord = sync2_r[2];
   assign live_timm = sync2_r[3];
   // (R01) either self-test
   assign ev_bist   = sync2_r[0] | sync2_r[1];
   // (R02) orderly with regs off
   assign ev_tord   = live_tord & regs_off;
   // (R07) immediate with regs off
   assign ev_timm   = live_timm & regs_off;
   // (R06) overvoltage with regs off
   assign ev_ovp    = sync2_r[4] & regs_off;
   // (R05) sequencer error
   assign ev_seq    = sync2_r[5];

   // ---------------------------------------------
   // Flag bank: [0]tord [1]bist [2]timm [3]ovp [4]seq
   // ---------------------------------------------
   flag_if #(.N(N)) fl ();

   function automatic logic wr_hit(input logic [7:0] a);
      wr_hit = reg_wr && (reg_addr == a);
   endfunction : wr_hit

   logic wr_mod;
   logic wr_sev;
   assign wr_mod = wr_hit(fault_flag_pkg::MODERATE_ADDR);
   // (R04) severe at 0x68
   assign wr_sev = wr_hit(fault_flag_pkg::SEVERE_ADDR);

   assign fl.set_ev = {ev_seq, ev_ovp, ev_timm, ev_bist, ev_tord};
   // (R09) only ones clear
   assign fl.clr = {wr_sev & reg_wdata[fault_flag_pkg::SEV_SEQ_BIT],
                    wr_sev & reg_wdata[fault_flag_pkg::SEV_OVP_BIT],
                    wr_sev & reg_wdata[fault_flag_pkg::SEV_TSD_BIT],
                    wr_mod & reg_wdata[fault_flag_pkg::MOD_BIST_BIT],
                    wr_mod & reg_wdata[fault_flag_pkg::MOD_TSD_BIT]};

   w1c_flag_bank #(.N(N)) bank (
      .clk  (clk),
      .srst (srst),
      .fl   (fl)
   );

   // ---------------------------------------------
   // Reserved read/write bits and read data
   // ---------------------------------------------
   logic [4:0] sev_rsv_r;
   logic [4:0] sev_rsv_nxt;
   logic [7:0] rdata_r;
   logic [7:0] rdata_nxt;
   logic [7:0] mod_view;
   logic [7:0] sev_view;

   always_comb begin
      mod_view = fault_flag_pkg::FLAG_RESET;
      mod_view[fault_flag_pkg::MOD_TSD_BIT]  = fl.flag[0];
      mod_view[fault_flag_pkg::MOD_BIST_BIT] = fl.flag[1];
      sev_view = {sev_rsv_r, fault_flag_pkg::FLAG_RESET[fault_flag_pkg::SEV_RSV_LO-1:0]};
      sev_view[fault_flag_pkg::SEV_TSD_BIT] = fl.flag[2];
      sev_view[fault_flag_pkg::SEV_OVP_BIT] = fl.flag[3];
      sev_view[fault_flag_pkg::SEV_SEQ_BIT] = fl.flag[4];
      sev_rsv_nxt = wr_sev ? reg_wdata[fault_flag_pkg::REG_W-1:fault_flag_pkg::SEV_RSV_LO] : sev_rsv_r;
      rdata_nxt = rdata_r;
      if (reg_rd) begin
         case (reg_addr)
            fault_flag_pkg::MODERATE_ADDR: rdata_nxt = mod_view;
            fault_flag_pkg::SEVERE_ADDR:   rdata_nxt = sev_view;
            fault_flag_pkg::MOD_STAT_ADDR: rdata_nxt = {7'h00, live_tord};
            fault_flag_pkg::SEV_STAT_ADDR: rdata_nxt = {7'h00, live_timm};
            default:                       rdata_nxt = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         // (R04) reset to 0x00
         sev_rsv_r <= fault_flag_pkg::FLAG_RESET[fault_flag_pkg::REG_W-1:fault_flag_pkg::SEV_RSV_LO];
         rdata_r   <= fault_flag_pkg::FLAG_RESET;
      end else begin
         sev_rsv_r <= sev_rsv_nxt;
         rdata_r   <= rdata_nxt;
      end
   end

   // Read data holds until the next read, so late sampling is safe
   assign reg_rdata = rdata_r;

   // Combinational, so a new flag blocks enable in the same cycle
   // (R03) (R08) thermal flags block enable
   assign regulator_enable_ok = regulator_enable_req & ~fl.flag[0] & ~fl.flag[2];

   // ---------------------------------------------
   // Checks
   // ---------------------------------------------
   sequence s_bist_seen;
      ev_bist;
   endsequence
   sequence s_seq_clear_req;
      fl.flag[4] && wr_sev && reg_wdata[fault_flag_pkg::SEV_SEQ_BIT] && !ev_seq;
   endsequence
   AST_BIST_LATCH: assert property (@(posedge clk) disable iff (srst) // (R01)
      s_bist_seen |=> fl.flag[1])
      else $error("self-test flag not set");
   AST_TORD_LATCH: assert property (@(posedge clk) disable iff (srst) // (R02)
      ev_tord |=> fl.flag[0])
      else $error("orderly thermal flag not set");
   AST_TORD_BLOCK: assert property (@(posedge clk) disable iff (srst) // (R03)
      fl.flag[0] |-> !regulator_enable_ok)
      else $error("enable passed with orderly flag");
   AST_SEV_RESET: assert property (@(posedge clk) // (R04)
      $past(srst) |-> (sev_view == fault_flag_pkg::FLAG_RESET))
      else $error("severe register not zero after reset");
   AST_SEQ_CLEAR: assert property (@(posedge clk) disable iff (srst) // (R05)
      s_seq_clear_req |=> !fl.flag[4])
      else $error("sequencer flag not cleared");
   AST_OVP_LATCH: assert property (@(posedge clk) disable iff (srst) // (R06)
      ev_ovp |=> fl.flag[3])
      else $error("overvoltage flag not set");
   AST_TIMM_LATCH: assert property (@(posedge clk) disable iff (srst) // (R07)
      ev_timm |=> fl.flag[2] ##0 sev_view[fault_flag_pkg::SEV_TSD_BIT])
      else $error("immediate thermal flag not set");
   AST_TIMM_BLOCK: assert property (@(posedge clk) disable iff (srst) // (R08)
      fl.flag[2] |-> !regulator_enable_ok)
      else $error("enable passed with immediate flag");
   AST_ZERO_WRITE: assert property (@(posedge clk) disable iff (srst) // (R09)
      (fl.flag[1] && wr_mod && !reg_wdata[fault_flag_pkg::MOD_BIST_BIT]) |=> fl.flag[1])
      else $error("zero write cleared flag");

   // ---------------------------------------------
   // Clear, hold and qualifier checks
   // ---------------------------------------------
   AST_BIST_CLEAR: assert property (@(posedge clk) disable iff (srst) // (R01)
      (fl.flag[1] && wr_mod && reg_wdata[fault_flag_pkg::MOD_BIST_BIT] && !ev_bist) |=> !fl.flag[1])
      else $error("self-test flag not cleared");
   AST_TORD_CLEAR: assert property (@(posedge clk) disable iff (srst) // (R02)
      (fl.flag[0] && wr_mod && reg_wdata[fault_flag_pkg::MOD_TSD_BIT] && !ev_tord) |=> !fl.flag[0])
      else $error("orderly thermal flag not cleared");
   AST_ENABLE_PASS: assert property (@(posedge clk) disable iff (srst) // (R03) (R08)
      (!fl.flag[0] && !fl.flag[2]) |-> (regulator_enable_ok == regulator_enable_req))
      else $error("enable refused with no thermal flag");
   AST_RSV_WRITE: assert property (@(posedge clk) disable iff (srst) // (R04)
      wr_sev |=> (sev_rsv_r == $past(reg_wdata[fault_flag_pkg::REG_W-1:fault_flag_pkg::SEV_RSV_LO])))
      else $error("reserved bits not written");
   AST_RSV_HOLD: assert property (@(posedge clk) disable iff (srst) // (R04)
      !wr_sev |=> $stable(sev_rsv_r))
      else $error("reserved bits changed without write");
   AST_SEQ_HOLD: assert property (@(posedge clk) disable iff (srst) // (R05)
      (fl.flag[4] && !wr_sev) |=> fl.flag[4])
      else $error("sequencer flag dropped");
   AST_OVP_CLEAR: assert property (@(posedge clk) disable iff (srst) // (R06)
      (fl.flag[3] && wr_sev && reg_wdata[fault_flag_pkg::SEV_OVP_BIT] && !ev_ovp) |=> !fl.flag[3])
      else $error("overvoltage flag not cleared");
   AST_TIMM_CLEAR: assert property (@(posedge clk) disable iff (srst) // (R07)
      (fl.flag[2] && wr_sev && reg_wdata[fault_flag_pkg::SEV_TSD_BIT] && !ev_timm) |=> !fl.flag[2])
      else $error("immediate thermal flag not cleared");
   AST_NO_LATCH_RUNNING: assert property (@(posedge clk) disable iff (srst) // (R02) (R06) (R07)
      (!regs_off && fl.flag[3:2] == 2'b00 && !fl.flag[0]) |=> (fl.flag[3:2] == 2'b00 && !fl.flag[0]))
      else $error("shutdown flag latched while regulators on");
   AST_SEV_SET_WINS: assert property (@(posedge clk) disable iff (srst) // (R09)
      (ev_seq && wr_sev && reg_wdata[fault_flag_pkg::SEV_SEQ_BIT]) |=> fl.flag[4])
      else $error("sequencer flag lost to clear");
endmodule : fault_latch_flags

// >>> logic/fault_flag_pkg.sv
// Notes on behaviour
// (R01) Self-test failure from logic or analog test sets moderate bit 1; write 1 clears.
// (R02) Orderly thermal shutdown with regulators off latches moderate bit 0; write 1 clears.
// (R03) Orderly thermal flag set blocks regulator enabling; live level reported unlatched.
// (R04) Severe flag register sits at offset 0x68 and resets to 0x00.
// (R05) Power sequencer internal error sets severe bit 2; write 1 clears.
// (R06) Input overvoltage with regulators disabled latches severe bit 1; write 1 clears.
// (R07) Immediate thermal shutdown with regulators disabled latches severe bit 0; write 1 clears.
// (R08) Immediate thermal flag set blocks regulator enabling; live level reported unlatched.
// (R09) Writing 0 leaves flags alone; an event during a clear keeps the flag set.
package fault_flag_pkg;
   localparam int          REG_W          = 8;
   localparam int          ADDR_W         = 8;
   localparam logic [7:0]  SEVERE_ADDR    = 8'h68;
   localparam logic [7:0]  MODERATE_ADDR  = 8'h67;
   localparam logic [7:0]  MOD_STAT_ADDR  = 8'h6a;
   localparam logic [7:0]  SEV_STAT_ADDR  = 8'h6b;
   localparam logic [7:0]  FLAG_RESET     = 8'h00;
   localparam int          MOD_TSD_BIT    = 0;
   localparam int          MOD_BIST_BIT   = 1;
   localparam int          SEV_TSD_BIT    = 0;
   localparam int          SEV_OVP_BIT    = 1;
   localparam int          SEV_SEQ_BIT    = 2;
   localparam int          SEV_RSV_LO     = 3;
   localparam int          NUM_FLAGS      = 5;
endpackage : fault_flag_pkg

// >>> logic/flag_if.sv
`timescale 1ns/10ps
interface flag_if #(parameter int N = 5);
   logic [N-1:0] set_ev;
   logic [N-1:0] clr;
   logic [N-1:0] flag;
   modport owner (input set_ev, input clr, output flag);
   modport user  (output set_ev, output clr, input flag);
endinterface : flag_if

// >>> logic/w1c_flag_bank.sv
`timescale 1ns/10ps
module w1c_flag_bank #(
   parameter int N = 5
) (
   // Clock and reset
   input  wire logic clk,
   input  wire logic srst,
   // Flag traffic
   flag_if.owner     fl
);
   logic [N-1:0] flag_r;
   logic [N-1:0] flag_nxt;

   // Checks below watch slots 0 and 1
   if (N < 2) begin : g_bad_n
      $error("w1c_flag_bank needs at least two flags");
   end

   // (R09) set beats clear
   always_comb begin
      flag_nxt = (flag_r & ~fl.clr) | fl.set_ev;
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         flag_r <= '0;
      end else begin
         flag_r <= flag_nxt;
      end
   end

   assign fl.flag = flag_r;

   // (R09) event held over clear
   AST_SET_WINS: assert property (@(posedge clk) disable iff (srst) // (R09)
      fl.set_ev[0] |=> flag_r[0])
      else $error("flag lost on set");
   AST_HOLD_NO_CLEAR: assert property (@(posedge clk) disable iff (srst) // (R09)
      (flag_r[1] && !fl.clr[1]) |=> flag_r[1])
      else $error("flag dropped without clear");
endmodule : w1c_flag_bank

// >>> test/reg_host.sv
`timescale 1ns/10ps
module reg_host (
   // Clock
   input  wire logic       clk,
   // Register port
   output logic            reg_wr,
   output logic            reg_rd,
   output logic      [7:0] reg_addr,
   output logic      [7:0] reg_wdata,
   input  wire logic [7:0] reg_rdata
);
   initial begin
      reg_wr    = 1'b0;
      reg_rd    = 1'b0;
      reg_addr  = 8'h00;
      reg_wdata = 8'h00;
   end

   // Strobe stands exactly one edge, so back to back calls never overlap
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      #1;
      reg_wr    = 1'b1;
      reg_addr  = a;
      reg_wdata = d;
      @(posedge clk);
      #1;
      reg_wr    = 1'b0;
      reg_wdata = ~d;
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk);
      #1;
      reg_rd   = 1'b1;
      reg_addr = a;
      @(posedge clk);
      #1;
      reg_rd   = 1'b0;
      d        = reg_rdata;
   endtask : rd
endmodule : reg_host

// >>> test/tb_top.sv
`timescale 1ns/10ps
module tb_top;
   logic       clk = 1'b0;
   logic       srst = 1'b1;
   logic       reg_wr, reg_rd, req, ok, roff;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, v;
   logic [5:0] ev;
   int         seed, errors, total_checks;
   logic [7:0] t_addr [6] = '{8'h67, 8'h67, 8'h67, 8'h68, 8'h68, 8'h68};
   logic [7:0] t_stat [6] = '{8'h00, 8'h00, 8'h6a, 8'h6b, 8'h00, 8'h00};
   int         t_bit  [6] = '{1, 1, 0, 0, 1, 2};
   logic       t_blk  [6] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0};

   always #2 clk = ~clk;

   reg_host u_host (.clk(clk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
                    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
   fault_latch_flags u_dut (.clk(clk), .srst(srst), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .logic_selftest_fail(ev[0]), .analog_selftest_fail(ev[1]), .temp_orderly_over(ev[2]),
      .temp_immediate_over(ev[3]), .input_supply_overvoltage(ev[4]), .power_sequencer_error(ev[5]),
      .regulators_off(roff), .regulator_enable_req(req), .regulator_enable_ok(ok));

   function automatic logic [7:0] mask_of(int b);
      return 8'h01 << b;
   endfunction : mask_of

   function automatic logic exp_ok(logic r, logic blocked);
      return r & ~blocked;
   endfunction : exp_ok

   task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
      total_checks++;
      if (got !== exp) begin
         errors++;
         $display("wrong value %s expected %h seen %h", name, exp, got);
      end
   endtask : check

   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp, input string name);
      logic [7:0] d;
      u_host.rd(a, d);
      check(name, exp, d);
   endtask : rd_chk

   task automatic conclude;
      $display("checks %0d errors %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : conclude

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      seed = 13;
      ev   = 6'h00;
      req  = 1'b0;
      roff = 1'b1;
      repeat (4) @(posedge clk);
      #1 srst = 1'b0;
      rd_chk(fault_flag_pkg::SEVERE_ADDR, 8'h00, "severe reset");
      rd_chk(fault_flag_pkg::MODERATE_ADDR, 8'h00, "moderate reset");
      rd_chk(8'h55, 8'h00, "unmapped read");
      $display("test reset done");
      // Regulators still on: levels show live but never latch
      roff    = 1'b0;
      ev[4:2] = 3'h7;
      repeat (4) @(posedge clk);
      rd_chk(fault_flag_pkg::MOD_STAT_ADDR, 8'h01, "live orderly running");
      rd_chk(fault_flag_pkg::SEV_STAT_ADDR, 8'h01, "live immediate running");
      rd_chk(fault_flag_pkg::MODERATE_ADDR, 8'h00, "orderly not latched");
      rd_chk(fault_flag_pkg::SEVERE_ADDR, 8'h00, "shutdown not latched");
      req     = 1'b1;
      ev[4:2] = 3'h0;
      #1 check("enable while running", 8'h01, {7'h00, ok});
      repeat (4) @(posedge clk);
      #1 roff = 1'b1;
      $display("test regulators running done");
      for (int i = 0; i < 6; i++) begin
         @(posedge clk);
         #1 ev[i] = 1'b1;
         repeat (4) @(posedge clk);
         if (t_stat[i] != 8'h00) rd_chk(t_stat[i], 8'h01, "live level high");
         // Held event beats a clear
         u_host.wr(t_addr[i], mask_of(t_bit[i]));
         rd_chk(t_addr[i], mask_of(t_bit[i]), "set wins");
         ev[i] = 1'b0;
         repeat (4) @(posedge clk);
         u_host.wr(t_addr[i], 8'h00);
         rd_chk(t_addr[i], mask_of(t_bit[i]), "latched flag");
         if (t_stat[i] != 8'h00) rd_chk(t_stat[i], 8'h00, "live level low");
         req = 1'($random(seed));
         #1 check("enable ok", {7'h00, exp_ok(req, t_blk[i])}, {7'h00, ok});
         u_host.wr(t_addr[i], mask_of(t_bit[i]));
         rd_chk(t_addr[i], 8'h00, "cleared flag");
         req = 1'b1;
         #1 check("enable after clear", 8'h01, {7'h00, ok});
         $display("test flag %0d done", i);
      end
      v = 8'($random(seed));
      u_host.wr(fault_flag_pkg::SEVERE_ADDR, v);
      rd_chk(fault_flag_pkg::SEVERE_ADDR, v & 8'hf8, "reserved bits");
      u_host.wr(8'h55, 8'hff);
      rd_chk(fault_flag_pkg::SEVERE_ADDR, v & 8'hf8, "unmapped write");
      ev[5] = 1'b1;
      repeat (4) @(posedge clk);
      rd_chk(fault_flag_pkg::SEVERE_ADDR, (v & 8'hf8) | 8'h04, "sequencer before reset");
      ev[5] = 1'b0;
      srst  = 1'b1;
      @(posedge clk);
      #1 srst = 1'b0;
      rd_chk(fault_flag_pkg::SEVERE_ADDR, 8'h00, "mid run reset");
      $display("test reserved and reset done");
      conclude();
   end
endmodule : tb_top
